// >>> rtl/dtsc_clk_sel.sv
`timescale 1ns/1ps
`include "dtsc_map.svh"

module dtsc_clk_sel
    import dtsc_pkg::*;
#(
    parameter int unsigned SWITCH_CYC = `DTSC_SW_TIME_US * `DTSC_CLK_MHZ
) (
    input  wire logic       clk,      // Reference clock.
    input  wire logic       rst,      // Synchronous reset, active high.
    input  wire logic       xtal_in,  // Crystal clock pin, asynchronous.
    input  wire logic       lpo_in,   // Internal 32 kHz clock, asynchronous.
    input  wire logic       src_sel,  // Requested source, high for 32 kHz.
    output dtsc_tick_s      sel       // Tick, busy and active source.
);

    localparam int CW = $clog2(SWITCH_CYC + 1);

    logic [2:0]    xs;
    logic [2:0]    ls;
    logic          xf;
    logic          xf_d;
    logic          lf;
    logic          lf_d;
    logic          x_tick;
    logic          l_tick;
    dtsc_state_e   st;
    logic [CW-1:0] cnt;

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    // Three stages; the level is only taken once stages two and three agree,
    // so a sample caught mid-transition never makes a tick of its own.
    always_ff @(posedge clk) begin
        if (rst) begin
            xs <= `DTSC_SYNC_RST;
            ls <= `DTSC_SYNC_RST;
        end else begin
            xs <= {xs[1:0], xtal_in};
            ls <= {ls[1:0], lpo_in};
        end
    end

    // Filtered levels and their previous values for edge detection.
    always_ff @(posedge clk) begin
        if (rst) begin
            xf   <= 1'b0;
            xf_d <= 1'b0;
            lf   <= 1'b0;
            lf_d <= 1'b0;
        end else begin
            if (xs[1] == xs[2]) begin
                xf <= xs[2];
            end
            if (ls[1] == ls[2]) begin
                lf <= ls[2];
            end
            xf_d <= xf;
            lf_d <= lf;
        end
    end

    // One tick per rising edge of each source.
    assign x_tick = xf & ~xf_d;
    assign l_tick = lf & ~lf_d;

    // -------------------------------------------------------------------------
    // Source switch sequencer
    // -------------------------------------------------------------------------
    // Going to 32 kHz waits the full switch time with no ticks passed; going
    // back to the crystal is immediate, as its ticks are always single pulses.
    always_ff @(posedge clk) begin
        if (rst) begin
            st  <= DTSC_RUN_XTAL;
            cnt <= '0;
        end else begin
            unique case (st)
                DTSC_RUN_XTAL: begin
                    cnt <= '0;
                    if (src_sel) begin
                        st <= DTSC_SWITCH; // R9
                    end
                end
                DTSC_SWITCH: begin
                    cnt <= cnt + CW'(1);
                    if (!src_sel) begin
                        st <= DTSC_RUN_XTAL;
                    end else if (cnt == CW'(SWITCH_CYC - 1)) begin
                        st <= DTSC_RUN_LPO; // R9
                    end
                end
                DTSC_RUN_LPO: begin
                    cnt <= '0;
                    if (!src_sel) begin
                        st <= DTSC_RUN_XTAL;
                    end
                end
            endcase
        end
    end

    // Gate the tick streams so only the active source reaches the counter.
    // One assignment drives the whole carrier, so it has a single driver.
    assign sel = '{
        tick: (st == DTSC_RUN_XTAL) ? x_tick : ((st == DTSC_RUN_LPO) ? l_tick : 1'b0), // R6 R13
        busy: (st == DTSC_SWITCH), // R13
        src:  (st == DTSC_RUN_LPO) ? DTSC_SRC_LPO : DTSC_SRC_XTAL
    };

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    switch_quiet_a : assert property ( // R13
        @(posedge clk) disable iff (rst) sel.busy |-> !sel.tick)
        else $error("Tick passed during a source switch.");

    lpo_follow_a : assert property ( // R6
        @(posedge clk) disable iff (rst)
        (sel.src == DTSC_SRC_LPO && !sel.busy) |-> (sel.tick == l_tick))
        else $error("32 kHz source active but tick does not follow it.");

endmodule

// >>> rtl/dtsc_map.svh
`ifndef DTSC_MAP_SVH
`define DTSC_MAP_SVH

// -----------------------------------------------------------------------------
// Reset values, steps and the all-ones wrap value
// -----------------------------------------------------------------------------
`define DTSC_TS_RST      32'h0000_0000
`define DTSC_INC_RST     32'h0000_0000
`define DTSC_TS_ALL_ONES 32'hffff_ffff
`define DTSC_TS_STEP     32'h0000_0001
`define DTSC_SYNC_RST    3'h0

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define DTSC_SW_TIME_US  220
`define DTSC_CLK_MHZ     100

`endif

// >>> rtl/dtsc_pkg.sv
package dtsc_pkg;

    // -------------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------------
    // Which tick source currently drives the timestamp.
    typedef enum logic {
        DTSC_SRC_XTAL,
        DTSC_SRC_LPO
    } dtsc_src_e;

    // Source switch sequencer states.
    typedef enum {
        DTSC_RUN_XTAL,
        DTSC_SWITCH,
        DTSC_RUN_LPO
    } dtsc_state_e;

    // Tick stream handed from the source selector to the timestamp counter.
    typedef struct packed {
        logic      tick;
        logic      busy;
        dtsc_src_e src;
    } dtsc_tick_s;

endpackage

// >>> rtl/dtsc_top.sv
`timescale 1ns/1ps
`include "dtsc_map.svh"

// How it works
// R1 - One shared timestamp output for every processor.
// R2 - 32-bit up counter running straight from reset.
// R3 - All-ones rolls to zero, no flag.
// R4 - Software write loads count; counting continues onward.
// R5 - Separate increment counter, advanced without locking.
// R6 - Tick source is crystal or 32 kHz.
// R7 - Gated crystal halts counter, registers hold.
// R8 - Crystal returns, counting resumes at once.
// R9 - Switch to 32 kHz waits 220 us.
// R10 - Software must not write during the switch.
// R11 - Deep-sleep wakeup returns every register to reset.
// R12 - One step per tick; write beats tick.
// R13 - Glitch-free switch with a visible busy flag.

module dtsc_top
    import dtsc_pkg::*;
#(
    parameter int unsigned SWITCH_CYC = `DTSC_SW_TIME_US * `DTSC_CLK_MHZ,
    parameter int unsigned NUM_REQ    = 4
) (
    input  wire logic               REF_CLK,      // 100 MHz reference clock.
    input  wire logic               SYS_RST,      // Synchronous reset, active high.
    input  wire logic               DSLP_WAKE,    // Deep-sleep wakeup pulse.
    input  wire logic               XTAL_CLK_IN,  // Crystal tick source pin.
    input  wire logic               LPO_CLK_IN,   // Internal 32 kHz tick source.
    input  wire logic               SRC_SEL,      // Source select, high for 32 kHz.
    input  wire logic               TS_WR_EN,     // Timestamp write strobe.
    input  wire logic [31:0]        TS_WR_DATA,   // Timestamp write value.
    input  wire logic [NUM_REQ-1:0] INC_REQ,      // One increment request each.
    output logic      [31:0]        TS_VALUE,     // Shared timestamp.
    output logic      [31:0]        INC_VALUE,    // Lock-free counter value.
    output logic                    SWITCH_BUSY,  // Source switch in progress.
    output logic                    TS_SRC        // Active source, high for 32 kHz.
);

    // -------------------------------------------------------------------------
    // Local signals
    // -------------------------------------------------------------------------
    logic        rst;
    dtsc_tick_s  sel;
    logic        wr_ok;
    logic [31:0] ts;
    logic [31:0] inc;
    logic [31:0] next_ts;
    logic [31:0] next_inc;
    logic [31:0] busy_len;
    logic        rst_d;

    // Counts the requests raised in one cycle; all land in the same cycle.
    function automatic logic [31:0] count_req(input logic [NUM_REQ-1:0] req);
        logic [31:0] sum;
        sum = '0;
        for (int i = 0; i < NUM_REQ; i++) begin
            sum = sum + {31'h0, req[i]};
        end
        return sum;
    endfunction

    // -------------------------------------------------------------------------
    // Reset
    // -------------------------------------------------------------------------
    // Deep-sleep wakeup acts exactly like the system reset on every register.
    assign rst = SYS_RST | DSLP_WAKE; // R11

    // -------------------------------------------------------------------------
    // Tick source selection
    // -------------------------------------------------------------------------
    dtsc_clk_sel #(
        .SWITCH_CYC (SWITCH_CYC)
    ) u_clk_sel (
        .clk     (REF_CLK),
        .rst     (rst),
        .xtal_in (XTAL_CLK_IN),
        .lpo_in  (LPO_CLK_IN),
        .src_sel (SRC_SEL),
        .sel     (sel)
    );

    // -------------------------------------------------------------------------
    // Timestamp counter
    // -------------------------------------------------------------------------
    // Writes arriving mid-switch are dropped; the far side must hold off, and
    // dropping keeps a half-switched source from ever seeing a new value.
    assign wr_ok = TS_WR_EN & ~sel.busy; // R10

    // Write first, then tick; with no tick nothing moves, so a gated crystal
    // simply freezes the count and the first returning edge counts again.
    always_comb begin
        next_ts = ts;
        if (wr_ok) begin
            next_ts = TS_WR_DATA; // R4 R12
        end else if (sel.tick) begin
            next_ts = ts + `DTSC_TS_STEP; // R2 R3 R7 R8 R12
        end
    end

    // The counter needs no enable bit: it runs from the first tick after reset.
    always_ff @(posedge REF_CLK) begin
        if (rst) begin
            ts <= `DTSC_TS_RST; // R11
        end else begin
            ts <= next_ts; // R2
        end
    end

    // -------------------------------------------------------------------------
    // Lock-free increment counter
    // -------------------------------------------------------------------------
    // Every requester has its own line, so simultaneous requests all count and
    // no processor ever needs a lock around the update.
    assign next_inc = inc + count_req(INC_REQ); // R5

    always_ff @(posedge REF_CLK) begin
        if (rst) begin
            inc <= `DTSC_INC_RST; // R11
        end else begin
            inc <= next_inc; // R5
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    // One timestamp feeds every processor, so messages stamped anywhere order.
    assign TS_VALUE    = ts; // R1
    assign INC_VALUE   = inc;
    assign SWITCH_BUSY = sel.busy; // R13
    assign TS_SRC      = (sel.src == DTSC_SRC_LPO);

    // -------------------------------------------------------------------------
    // Check helpers
    // -------------------------------------------------------------------------
    // Length of the current busy stretch, read only by the checks below.
    always_ff @(posedge REF_CLK) begin
        if (rst) begin
            busy_len <= '0;
        end else if (sel.busy) begin
            busy_len <= busy_len + 32'h1;
        end else begin
            busy_len <= '0;
        end
    end

    // Reset seen one edge ago. Checks that look back one cycle stand down for
    // that edge, as the values they would compare belong to the run before.
    always_ff @(posedge REF_CLK) begin
        rst_d <= rst;
    end

    // -------------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------------
    ts_write_load_a : assert property ( // R4
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (TS_WR_EN && !SWITCH_BUSY) |=> (TS_VALUE == $past(TS_WR_DATA)))
        else $error("Timestamp write did not load the written value.");

    ts_step_a : assert property ( // R12
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (sel.tick && !TS_WR_EN) |=> (TS_VALUE == $past(TS_VALUE) + 32'h1))
        else $error("Timestamp did not step by one on a tick.");

    ts_hold_a : assert property ( // R7
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (!sel.tick && !wr_ok) |=> $stable(TS_VALUE))
        else $error("Timestamp moved without a tick or write.");

    ts_wrap_a : assert property ( // R3
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (TS_VALUE == `DTSC_TS_ALL_ONES && sel.tick && !TS_WR_EN) |=> (TS_VALUE == '0))
        else $error("Timestamp did not roll over to zero.");

    inc_sum_a : assert property ( // R5
        @(posedge REF_CLK) disable iff (rst || rst_d)
        1'b1 |=> (INC_VALUE == $past(INC_VALUE) + count_req($past(INC_REQ))))
        else $error("Increment counter lost or added a request.");

    wake_clear_a : assert property ( // R11
        @(posedge REF_CLK) disable iff (SYS_RST)
        DSLP_WAKE |=> (TS_VALUE == '0 && INC_VALUE == '0 && !SWITCH_BUSY && !TS_SRC))
        else $error("Deep-sleep wakeup left state behind.");

    switch_len_a : assert property ( // R9
        @(posedge REF_CLK) disable iff (rst || rst_d)
        ($fell(SWITCH_BUSY) && TS_SRC) |-> (busy_len == SWITCH_CYC))
        else $error("Switch to 32 kHz did not last the switch time.");

    busy_drop_a : assert property ( // R10
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (SWITCH_BUSY && TS_WR_EN) |=> $stable(TS_VALUE))
        else $error("Write during source switch changed the timestamp.");

    switch_start_a : assert property ( // R13
        @(posedge REF_CLK) disable iff (rst || rst_d)
        ($rose(SRC_SEL) && !TS_SRC && !SWITCH_BUSY) |=> (SWITCH_BUSY && !TS_SRC))
        else $error("Busy did not rise when 32 kHz was selected.");

    start_run_a : assert property ( // R2
        @(posedge REF_CLK) disable iff (SYS_RST || DSLP_WAKE)
        $fell(rst) |-> (TS_VALUE == '0 && !SWITCH_BUSY))
        else $error("Counter did not start from zero after reset.");

    resume_a : assert property ( // R8
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (!TS_SRC && !SWITCH_BUSY && sel.tick && !TS_WR_EN) |=> (TS_VALUE != $past(TS_VALUE)))
        else $error("Crystal tick did not advance the timestamp.");

    write_wins_a : assert property ( // R12
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (sel.tick && wr_ok) |=> (TS_VALUE == $past(TS_WR_DATA)))
        else $error("Tick beat a write in the same cycle.");

    switch_abort_a : assert property ( // R13
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (SWITCH_BUSY && !SRC_SEL) |=> (!SWITCH_BUSY && !TS_SRC))
        else $error("Dropped select did not abort the switch.");

    xtal_return_a : assert property ( // R6
        @(posedge REF_CLK) disable iff (rst || rst_d)
        (TS_SRC && !SRC_SEL) |=> (!TS_SRC && !SWITCH_BUSY))
        else $error("Return to the crystal was not immediate.");

endmodule

// >>> tb/test_dtsc_top.sv
`timescale 1ns/1ps

module test_dtsc_top
    import dtsc_pkg::*;
;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    localparam int unsigned SW_CYC = 20;

    typedef struct {
        int          id;
        logic [31:0] v;
    } dtsc_note_s;

    logic        ref_clk     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic        dslp_wake   = 1'b0;
    logic        xtal_in     = 1'b0;
    logic        lpo_in      = 1'b0;
    logic        src_sel     = 1'b0;
    logic        ts_wr_en    = 1'b0;
    logic [31:0] ts_wr_data  = 32'h0;
    logic [3:0]  inc_req     = 4'h0;
    logic [31:0] ts_value;
    logic [31:0] inc_value;
    logic        switch_busy;
    logic        ts_src;
    logic [31:0] ts_exp      = 32'h0;
    logic [31:0] inc_exp     = 32'h0;
    logic [31:0] busy_len    = 32'h0;
    logic [31:0] rng         = 32'hd7fa73fa;
    int          mismatches  = 0;
    int          n_checks    = 0;
    dtsc_note_s  notes[$];

    dtsc_top #(
        .SWITCH_CYC (SW_CYC),
        .NUM_REQ    (4)
    ) dut (
        .REF_CLK     (ref_clk),
        .SYS_RST     (sys_rst),
        .DSLP_WAKE   (dslp_wake),
        .XTAL_CLK_IN (xtal_in),
        .LPO_CLK_IN  (lpo_in),
        .SRC_SEL     (src_sel),
        .TS_WR_EN    (ts_wr_en),
        .TS_WR_DATA  (ts_wr_data),
        .INC_REQ     (inc_req),
        .TS_VALUE    (ts_value),
        .INC_VALUE   (inc_value),
        .SWITCH_BUSY (switch_busy),
        .TS_SRC      (ts_src)
    );

    // 100 MHz reference clock.
    always #5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Xorshift keeps the run repeatable without a simulator seed.
    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // The driver notes what an output must show once the current edge settles.
    task automatic note(input int id, input logic [31:0] v);
        notes.push_back('{id, v});
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each level is held six cycles so the input filter always accepts it.
    task automatic pulse(input bit use_lpo);
        @(posedge ref_clk);
        if (use_lpo) lpo_in <= 1'b1;
        else xtal_in <= 1'b1;
        repeat (6) @(posedge ref_clk);
        if (use_lpo) lpo_in <= 1'b0;
        else xtal_in <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic ts_write(input logic [31:0] d);
        @(posedge ref_clk);
        ts_wr_en   <= 1'b1;
        ts_wr_data <= d;
        @(posedge ref_clk);
        ts_wr_en   <= 1'b0;
        ts_exp = d;
    endtask

    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------------------
    // Outputs are compared mid-cycle, well clear of the launching edge.
    always @(negedge ref_clk) begin
        while (notes.size() > 0) begin
            dtsc_note_s n;
            n = notes.pop_front();
            case (n.id)
                0: check("ts_value", ts_value, n.v);
                1: check("inc_value", inc_value, n.v);
                2: check("switch_busy", {31'h0, switch_busy}, n.v);
                3: check("ts_src", {31'h0, ts_src}, n.v);
                default: check("busy_len", busy_len, n.v);
            endcase
        end
    end

    // A hang costs a mismatch and ends the run the normal way.
    initial begin
        #50us;
        mismatches++;
        end_sim();
    end

    // ------------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        note(0, 32'h0);
        note(1, 32'h0);
        note(2, 32'h0);
        note(3, 32'h0);
        repeat (6) @(posedge ref_clk);
        // Counting starts with no enable from software.
        pulse(1'b0);
        note(0, 32'h1);
        // Back-to-back writes: the later word wins.
        @(posedge ref_clk);
        ts_wr_en   <= 1'b1;
        ts_wr_data <= next_rand();
        ts_write(next_rand());
        note(0, ts_exp);
        pulse(1'b0);
        note(0, ts_exp + 32'h1);
        // All-ones rolls over to zero and keeps going.
        ts_write(32'hffffffff);
        note(0, 32'hffffffff);
        pulse(1'b0);
        note(0, 32'h0);
        pulse(1'b0);
        note(0, 32'h1);
        ts_exp = 32'h1;
        // Crystal stopped: the count holds, then resumes on the next edge.
        repeat (50) @(posedge ref_clk);
        note(0, ts_exp);
        pulse(1'b0);
        ts_exp = ts_exp + 32'h1;
        note(0, ts_exp);
        // A write landing with a crystal tick wins; that tick is lost.
        xtal_in <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ts_write(32'h0000_00a5);
        note(0, ts_exp);
        xtal_in <= 1'b0;
        repeat (6) @(posedge ref_clk);
        note(0, ts_exp);
        // Random increment requests, several in one cycle.
        repeat (30) begin
            @(posedge ref_clk);
            inc_req <= 4'(next_rand());
            inc_exp = inc_exp + 32'($countones(inc_req));
        end
        @(posedge ref_clk);
        inc_exp = inc_exp + 32'($countones(inc_req));
        inc_req <= 4'h0;
        @(posedge ref_clk);
        note(1, inc_exp);
        // Switch to the slow source; no writes are issued meanwhile.
        @(posedge ref_clk);
        src_sel <= 1'b1;
        fork
            repeat (60) begin
                @(negedge ref_clk);
                if (switch_busy === 1'b1) busy_len = busy_len + 32'h1;
            end
            begin
                pulse(1'b0);
                inc_req <= 4'hf;
                @(posedge ref_clk);
                inc_req <= 4'h0;
                inc_exp = inc_exp + 32'h4;
            end
        join
        @(posedge ref_clk);
        note(4, SW_CYC);
        note(0, ts_exp);
        note(1, inc_exp);
        note(3, 32'h1);
        pulse(1'b1);
        ts_exp = ts_exp + 32'h1;
        note(0, ts_exp);
        pulse(1'b0);
        note(0, ts_exp);
        // Back to the crystal takes effect at once.
        src_sel <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        note(3, 32'h0);
        note(2, 32'h0);
        pulse(1'b0);
        note(0, ts_exp + 32'h1);
        // Dropping the select mid-switch falls back to the crystal at once.
        src_sel <= 1'b1;
        repeat (5) @(posedge ref_clk);
        note(2, 32'h1);
        src_sel <= 1'b0;
        repeat (2) @(posedge ref_clk);
        note(2, 32'h0);
        note(3, 32'h0);
        // Deep-sleep wakeup clears every register.
        @(posedge ref_clk);
        dslp_wake <= 1'b1;
        @(posedge ref_clk);
        dslp_wake <= 1'b0;
        note(0, 32'h0);
        note(1, 32'h0);
        note(3, 32'h0);
        repeat (3) @(posedge ref_clk);
        end_sim();
    end

endmodule
